// [design/pmc_pkg.sv]
/*
  Constants, register map and carrier types for the proximity measurement control block.
  The I2C target logic and the measurement sequencer import this package.
*/
package pmc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_MODE_CTRL = 8'h02;
  localparam logic [7:0] CMD_LOW_THR   = 8'h03;
  localparam logic [7:0] CMD_HIGH_THR  = 8'h04;
  localparam logic [7:0] CMD_CANCEL    = 8'h05;
  localparam logic [7:0] CMD_RESULT    = 8'hF8;
  localparam logic [7:0] CMD_EVENTS    = 8'hF9;
  localparam logic [7:0] CMD_IDENT     = 8'hFA;

  // target addresses: straight and swapped pin wiring
  localparam logic [6:0] ADDR_STRAIGHT = 7'h60;
  localparam logic [6:0] ADDR_SWAPPED  = 7'h51;
  // identity codes, values arbitrary
  localparam logic [7:0] ID_LOW_STRAIGHT = 8'hA0;
  localparam logic [7:0] ID_LOW_SWAPPED  = 8'hA1;
  localparam logic [7:0] ID_HIGH         = 8'h0B;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int MODE_SEL_BIT    = 4;
  localparam int TRIGGER_BIT     = 5;
  localparam int FAST_PERIOD_LSB = 14;
  localparam int SUN_FLAG_BIT    = 12;
  localparam int NEAR_FLAG_BIT   = 9;
  localparam int FAR_FLAG_BIT    = 8;
  localparam logic [15:0] RESET_WORD    = 16'h0000;
  localparam logic [15:0] MODE_CTRL_WMASK = 16'hC030;
  localparam logic [15:0] CANCEL_MASK   = 16'h0FFF;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int FAST_PERIOD_1_US = 6250;
  localparam int FAST_PERIOD_2_US = 12500;
  localparam int FAST_PERIOD_3_US = 25000;
  localparam int NORMAL_PERIOD_US = 50000;
  localparam int FAST_1_CYC = FAST_PERIOD_1_US * (CLK_HZ / 1_000_000);
  localparam int FAST_2_CYC = FAST_PERIOD_2_US * (CLK_HZ / 1_000_000);
  localparam int FAST_3_CYC = FAST_PERIOD_3_US * (CLK_HZ / 1_000_000);
  localparam int NORMAL_CYC = NORMAL_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int MEASURE_CYC = 16;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        high_dynamic_range;
    logic        adc_gain_select;
    logic [1:0]  integration_time;
  } pmc_range_t;

  typedef struct packed {
    logic        done;
    logic [15:0] result;
  } pmc_meas_t;

  typedef struct packed {
    logic        sun;
    logic        near;
    logic        far;
  } pmc_event_t;

endpackage

// [design/pmc_sync.sv]
/*
  Two-flop synchroniser for the bus pins.
  Assumes the inputs are asynchronous to mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_sync (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_q <= 1'b1;
      sync_o <= 1'b1;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// [design/pmc_measure.sv]
/*
  Measurement sequencer: period timer, forced trigger, ceiling clamp.
  Assumes raw samples arrive from the analog front end on mclk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_measure
  import pmc_pkg::*;
#(
  parameter int FAST_1 = FAST_1_CYC,
  parameter int FAST_2 = FAST_2_CYC,
  parameter int FAST_3 = FAST_3_CYC,
  parameter int NORMAL = NORMAL_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire pmc_range_t  range_i,
  input  wire logic        forced_mode_i,
  input  wire logic        trigger_i,
  input  wire logic [1:0]  fast_period_i,
  input  wire logic [15:0] raw_sample_i,
  output pmc_meas_t        meas_o
);
  typedef enum logic [1:0] {ST_WAIT, ST_CONVERT, ST_DONE} pmc_mstate_t;

  pmc_mstate_t state_q;
  logic [21:0] period_q;
  logic [4:0]  conv_q;
  logic [21:0] period_limit;

  // ceiling as all-ones of the selected bit count
  function automatic logic [15:0] ceiling(input pmc_range_t r);
    logic [2:0] extra;
    extra = 3'({1'b0, r.integration_time}) + 3'(r.adc_gain_select);
    if (!r.high_dynamic_range) begin
      ceiling = 16'h0FFF;
    end else begin
      ceiling = 16'((17'h01000 << extra) - 17'h00001);
    end
  endfunction

  always_comb begin
    case (fast_period_i)
      2'd1:    period_limit = 22'(FAST_1);
      2'd2:    period_limit = 22'(FAST_2);
      2'd3:    period_limit = 22'(FAST_3);
      default: period_limit = 22'(NORMAL);
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_q  <= ST_WAIT;
      period_q <= 22'h000000;
      conv_q   <= 5'h00;
      meas_o   <= '0;
    end else begin
      meas_o.done <= 1'b0;
      case (state_q)
        ST_WAIT: begin
          period_q <= period_q + 22'h000001;
          if (forced_mode_i) begin
            period_q <= 22'h000000;
            if (trigger_i) begin
              state_q <= ST_CONVERT;
            end
          end else if (period_q >= period_limit - 22'h000001) begin
            period_q <= 22'h000000;
            state_q  <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          conv_q <= conv_q + 5'h01;
          if (conv_q == 5'(MEASURE_CYC - 1)) begin
            conv_q <= 5'h00;
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          meas_o.done <= 1'b1;
          if (raw_sample_i > ceiling(range_i)) begin
            meas_o.result <= ceiling(range_i);
          end else begin
            meas_o.result <= raw_sample_i;
          end
          state_q <= ST_WAIT;
        end
        default: state_q <= ST_WAIT;
      endcase
    end
  end
endmodule
`default_nettype wire

// [design/pmc_top.sv]
/*
  I2C target holding the measurement control and result registers.
  Assumes open-drain bus pins resolved outside; range fields and the
  sunlight event come from neighbouring configuration logic.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_top
  import pmc_pkg::*;
#(
  parameter int FAST_1 = FAST_1_CYC,
  parameter int FAST_2 = FAST_2_CYC,
  parameter int FAST_3 = FAST_3_CYC,
  parameter int NORMAL = NORMAL_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  input  wire logic        pins_swapped_i,
  input  wire pmc_range_t  range_i,
  input  wire logic        sun_event_i,
  input  wire logic [15:0] raw_sample_i,
  output logic             measure_done_o
);
  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_prev_q;
  logic sda_prev_q;
  logic swap_s;

  pmc_sync u_scl_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (scl_i),
    .sync_o  (scl_s)
  );
  pmc_sync u_sda_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (sda_i),
    .sync_o  (sda_s)
  );
  // swap strap is a pin level too; settles long before any frame can start
  pmc_sync u_swap_sync (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .async_i (pins_swapped_i),
    .sync_o  (swap_s)
  );

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  wire scl_rise = scl_s && !scl_prev_q;
  wire scl_fall = !scl_s && scl_prev_q;
  wire start_c  = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  wire stop_c   = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] mode_ctrl_q;
  logic [15:0] low_thr_q;
  logic [15:0] high_thr_q;
  logic [15:0] cancel_q;
  logic [15:0] result_q;
  pmc_event_t  events_q;
  logic [6:0]  my_addr_q;
  logic [7:0]  id_low_q;
  pmc_meas_t   meas;

  // address strap followed every cycle after reset release
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      my_addr_q <= ADDR_STRAIGHT;
      id_low_q  <= ID_LOW_STRAIGHT;
    end else begin
      my_addr_q <= swap_s ? ADDR_SWAPPED : ADDR_STRAIGHT;
      id_low_q  <= swap_s ? ID_LOW_SWAPPED : ID_LOW_STRAIGHT;
    end
  end

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BS_IDLE, BS_SHIFT, BS_ACK, BS_SEND, BS_MACK
  } pmc_bstate_t;

  pmc_bstate_t bstate_q;
  logic [7:0]  shift_q;
  logic [3:0]  bitcnt_q;
  logic        rw_q;
  logic [1:0]  bytes_q;
  logic [7:0]  cmd_q;
  logic [7:0]  wlow_q;
  logic        wr_strobe_q;
  logic        rd_done_q;
  logic        sda_drive_q;
  logic [15:0] rdata;

  function automatic logic [15:0] read_mux(input logic [7:0] cmd,
                                           input logic [15:0] mc,
                                           input logic [15:0] lt,
                                           input logic [15:0] ht,
                                           input logic [15:0] cv,
                                           input logic [15:0] rs,
                                           input pmc_event_t  ev,
                                           input logic [7:0]  idl);
    logic [15:0] w;
    w = 16'h0000;
    case (cmd)
      CMD_MODE_CTRL: w = mc;
      CMD_LOW_THR:   w = lt;
      CMD_HIGH_THR:  w = ht;
      CMD_CANCEL:    w = cv & CANCEL_MASK;
      CMD_RESULT:    w = rs;
      CMD_EVENTS: begin
        w[SUN_FLAG_BIT]  = ev.sun;
        w[NEAR_FLAG_BIT] = ev.near;
        w[FAR_FLAG_BIT]  = ev.far;
      end
      CMD_IDENT:     w = {ID_HIGH, idl};
      default:       w = 16'h0000;
    endcase
    read_mux = w;
  endfunction

  assign rdata = read_mux(cmd_q, mode_ctrl_q, low_thr_q, high_thr_q, cancel_q,
                          result_q, events_q, id_low_q);

  // bytes_q: 0 address, 1 command or read data low, 2 write data low or read data high, 3 write data high
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bstate_q    <= BS_IDLE;
      shift_q     <= 8'h00;
      bitcnt_q    <= 4'h0;
      rw_q        <= 1'b0;
      bytes_q     <= 2'd0;
      cmd_q       <= 8'h00;
      wlow_q      <= 8'h00;
      wr_strobe_q <= 1'b0;
      rd_done_q   <= 1'b0;
      sda_drive_q <= 1'b0;
    end else begin
      wr_strobe_q <= 1'b0;
      rd_done_q   <= 1'b0;
      if (start_c) begin
        // repeated start keeps cmd_q for the read
        bstate_q    <= BS_SHIFT;
        bitcnt_q    <= 4'h0;
        bytes_q     <= 2'd0;
        sda_drive_q <= 1'b0;
      end else if (stop_c) begin
        bstate_q    <= BS_IDLE;
        sda_drive_q <= 1'b0;
      end else begin
        case (bstate_q)
          BS_IDLE: sda_drive_q <= 1'b0;
          BS_SHIFT: begin
            if (scl_rise) begin
              shift_q  <= {shift_q[6:0], sda_s};
              bitcnt_q <= bitcnt_q + 4'h1;
            end
            if (scl_fall && bitcnt_q == 4'h8) begin
              bitcnt_q <= 4'h0;
              if (bytes_q == 2'd0) begin
                if (shift_q[7:1] == my_addr_q) begin
                  rw_q        <= shift_q[0];
                  sda_drive_q <= 1'b1;
                  bstate_q    <= BS_ACK;
                end else begin
                  bstate_q <= BS_IDLE;
                end
              end else begin
                sda_drive_q <= 1'b1;
                bstate_q    <= BS_ACK;
                // low data byte waits here until the high byte is acked
                if (bytes_q == 2'd2 && !rw_q) begin
                  wlow_q <= shift_q;
                end
              end
            end
          end
          BS_ACK: begin
            if (scl_fall) begin
              sda_drive_q <= 1'b0;
              if (bytes_q == 2'd0 && rw_q) begin
                bytes_q     <= 2'd1;
                shift_q     <= rdata[7:0];
                sda_drive_q <= !rdata[7];
                bitcnt_q    <= 4'h1;
                bstate_q    <= BS_SEND;
              end else begin
                bstate_q <= BS_SHIFT;
                case (bytes_q)
                  2'd0: bytes_q <= 2'd1;
                  2'd1: begin
                    cmd_q   <= shift_q;
                    bytes_q <= 2'd2;
                  end
                  2'd2: bytes_q <= 2'd3;
                  // commit only after the high byte; a lone data byte stores nothing
                  default: begin
                    wr_strobe_q <= 1'b1;
                    bytes_q     <= 2'd3;
                  end
                endcase
              end
            end
          end
          BS_SEND: begin
            if (scl_fall) begin
              if (bitcnt_q == 4'h8) begin
                sda_drive_q <= 1'b0;
                bstate_q    <= BS_MACK;
              end else begin
                sda_drive_q <= !shift_q[7 - bitcnt_q[2:0]];
                bitcnt_q    <= bitcnt_q + 4'h1;
              end
            end
          end
          BS_MACK: begin
            if (scl_rise) begin
              if (sda_s || bytes_q == 2'd2) begin
                if (bytes_q == 2'd2) begin
                  rd_done_q <= 1'b1;
                end
                bstate_q <= BS_IDLE;
              end else begin
                bytes_q  <= 2'd2;
                shift_q  <= rdata[15:8];
                bitcnt_q <= 4'h0;
              end
            end
            if (scl_fall && bytes_q == 2'd2 && bitcnt_q == 4'h0) begin
              sda_drive_q <= !shift_q[7];
              bitcnt_q    <= 4'h1;
              bstate_q    <= BS_SEND;
            end
          end
          default: bstate_q <= BS_IDLE;
        endcase
      end
    end
  end

  // open-drain: enable low means pulling low
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sda_o      <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= !sda_drive_q;
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  wire [15:0] wword = {shift_q, wlow_q};

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode_ctrl_q <= RESET_WORD;
      low_thr_q   <= RESET_WORD;
      high_thr_q  <= RESET_WORD;
      cancel_q    <= RESET_WORD;
    end else begin
      if (wr_strobe_q) begin
        case (cmd_q)
          // reserved bits are forced to zero by the write mask
          CMD_MODE_CTRL: mode_ctrl_q <= wword & MODE_CTRL_WMASK;
          CMD_LOW_THR:   low_thr_q   <= wword;
          CMD_HIGH_THR:  high_thr_q  <= wword;
          CMD_CANCEL:    cancel_q    <= wword & CANCEL_MASK;
          default: ;
        endcase
      end
      // trigger self-clears once the cycle completes
      if (meas.done && !(wr_strobe_q && cmd_q == CMD_MODE_CTRL)) begin
        mode_ctrl_q[TRIGGER_BIT] <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // measurement, result and events
  // ---------------------------------------------------------------
  pmc_measure #(
    .FAST_1 (FAST_1),
    .FAST_2 (FAST_2),
    .FAST_3 (FAST_3),
    .NORMAL (NORMAL)
  ) u_measure (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .range_i       (range_i),
    .forced_mode_i (mode_ctrl_q[MODE_SEL_BIT]),
    .trigger_i     (mode_ctrl_q[TRIGGER_BIT] && !meas.done),
    .fast_period_i (mode_ctrl_q[FAST_PERIOD_LSB +: 2]),
    .raw_sample_i  (raw_sample_i),
    .meas_o        (meas)
  );

  wire rd_events = rd_done_q && cmd_q == CMD_EVENTS;
  wire near_hit  = meas.done && meas.result > high_thr_q && result_q <= high_thr_q;
  wire far_hit   = meas.done && meas.result < low_thr_q && result_q >= low_thr_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      result_q       <= RESET_WORD;
      events_q       <= '0;
      measure_done_o <= 1'b0;
    end else begin
      measure_done_o <= meas.done;
      if (meas.done) begin
        result_q <= meas.result;
      end
      // a new event beats the read-clear in the same cycle
      events_q.sun  <= sun_event_i || (events_q.sun && !rd_events);
      events_q.near <= near_hit || (events_q.near && !rd_events);
      events_q.far  <= far_hit || (events_q.far && !rd_events);
    end
  end
endmodule
`default_nettype wire

// [tb/pmc_props.sv]
/*
  Checker for the proximity control block: pin timing of the bus target
  and spacing of measurement pulses. Bound to pmc_top; sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_props (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  input  wire logic sda_o,
  input  wire logic sda_oe_n_o,
  input  wire logic measure_done_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  logic [7:0] idle_q;
  logic [7:0] low_q;

  // cycles of clock line high, saturating
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !scl_i) idle_q <= 8'h00;
    else if (idle_q != 8'hFF) idle_q <= idle_q + 8'h01;
  end

  // cycles the target holds data low; a zero byte plus ack bounds it
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || sda_oe_n_o) low_q <= 8'h00;
    else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
  end

  sequence scl_held_s;
    scl_i ##1 scl_i ##1 scl_i;
  endsequence
  sequence start_s;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence

  reset_pins_a: assert property (disable iff (1'b0) !rst_n_i |=>
    sda_oe_n_o && sda_o && !measure_done_o) else $error("pins not quiet in reset");
  drive_zero_a: assert property ($past(rst_n_i) |-> !sda_o)
    else $error("data drive value not zero");
  ack_timing_a: assert property ($fell(sda_oe_n_o) |-> !$past(scl_i, 2))
    else $error("drive began outside clock low phase");
  bit_stable_a: assert property (scl_held_s |-> $stable(sda_oe_n_o))
    else $error("data changed while clock high");
  drive_bound_a: assert property (low_q < 8'h50)
    else $error("data held low too long");
  idle_release_a: assert property (idle_q >= 8'h20 |-> sda_oe_n_o)
    else $error("data driven on idle bus");
  start_quiet_a: assert property (start_s |=> sda_oe_n_o [*8])
    else $error("drive during address bits");
  done_gap_a: assert property (measure_done_o |=> !measure_done_o [*8])
    else $error("measurement pulses too close");
endmodule
bind pmc_top pmc_props u_props (
  .mclk_i         (mclk_i),
  .rst_n_i        (rst_n_i),
  .scl_i          (scl_i),
  .sda_i          (sda_i),
  .sda_o          (sda_o),
  .sda_oe_n_o     (sda_oe_n_o),
  .measure_done_o (measure_done_o)
);
`default_nettype wire

// [tb/pmc_host_model.sv]
/*
  Bus controller model: two-byte word writes and repeated-start reads.
  Assumes the bench resolves the open-drain data line with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none
module pmc_host_model (
  input  wire logic mclk_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_drv_o
);
  // clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_drv_o = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // 8 cycles a bit: 160 ns; sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic r);
    tick(1);
    sda_drv_o = b;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    r = sda_line_i;
    scl_o = 1'b0;
  endtask

  task automatic start();
    tick(1);
    sda_drv_o = 1'b1;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    sda_drv_o = 1'b0;
    tick(4);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    tick(1);
    sda_drv_o = 1'b0;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    sda_drv_o = 1'b1;
    tick(4);
  endtask

  task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] r,
                         output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ab, ack);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d,
                    output logic nak);
    logic [7:0] r;
    logic [3:0] k;
    start();
    byte_io({a, 1'b0}, 1'b1, r, k[0]);
    byte_io(c, 1'b1, r, k[1]);
    byte_io(d[7:0], 1'b1, r, k[2]);
    byte_io(d[15:8], 1'b1, r, k[3]);
    stop();
    nak = |k;
  endtask

  // repeated start, no stop; low byte acked, high byte refused
  task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [15:0] d,
                    output logic nak);
    logic [2:0] k;
    logic       x;
    start();
    byte_io({a, 1'b0}, 1'b1, d[7:0], k[0]);
    byte_io(c, 1'b1, d[7:0], k[1]);
    start();
    byte_io({a, 1'b1}, 1'b1, d[7:0], k[2]);
    byte_io(8'hFF, 1'b0, d[7:0], x);
    byte_io(8'hFF, 1'b1, d[15:8], x);
    stop();
    nak = |k;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
/*
  Self-checking bench for pmc_top: registers, clamp, events, periods.
  Assumes shortened period parameters; the bench resolves the bus line.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pmc_pkg::*;
  localparam int PER [4] = '{1600, 200, 400, 800};
  logic       mclk, rst_n, scl, hsda, line, sda_o, oe_n, swapped, sun, done;
  pmc_range_t range;
  logic [15:0] raw, d;
  logic [6:0]  addr;
  logic        nak;
  int          n_errors, checks_done, cyc, n_done, t_prev, t_last, base;

  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  assign line = hsda & (oe_n | sda_o);

  pmc_top #(.FAST_1(200), .FAST_2(400), .FAST_3(800), .NORMAL(1600)) u_dut (
    .mclk_i(mclk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(line), .sda_o(sda_o),
    .sda_oe_n_o(oe_n), .pins_swapped_i(swapped), .range_i(range),
    .sun_event_i(sun), .raw_sample_i(raw), .measure_done_o(done));
  pmc_host_model u_host (.mclk_i(mclk), .sda_line_i(line), .scl_o(scl), .sda_drv_o(hsda));

  always @(negedge mclk) if (done === 1'b1) begin
    n_done++;
    t_prev = t_last;
    t_last = cyc;
  end

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] c, input logic [15:0] v);
    u_host.wr(addr, c, v, nak);
    check(nak, 1'b0);
  endtask
  task automatic reg_chk(input logic [7:0] c, input logic [15:0] e);
    u_host.rd(addr, c, d, nak);
    check(d, e);
    check(16'(nak), 16'h0000);
  endtask
  task automatic wait_done(input int target);
    for (int i = 0; i < 6000 && n_done < target; i++) @(negedge mclk);
    check(16'(n_done >= target), 16'h0001);
  endtask
  task automatic trig(input logic [15:0] v);
    @(negedge mclk);
    raw = v;
    base = n_done;
    reg_wr(CMD_MODE_CTRL, 16'h0030);
    wait_done(base + 1);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic s_ident();
    foreach (PER[i]) reg_chk(i == 0 ? CMD_RESULT : 8'(i + 2), RESET_WORD);
    reg_chk(CMD_IDENT, {ID_HIGH, ID_LOW_STRAIGHT});
    swapped = 1'b1;
    addr = ADDR_SWAPPED;
    reg_chk(CMD_IDENT, {ID_HIGH, ID_LOW_SWAPPED});
    addr = ADDR_STRAIGHT;
    u_host.rd(addr, CMD_IDENT, d, nak);
    check(nak, 1'b1);
    swapped = 1'b0;
  endtask

  task automatic s_regs();
    reg_wr(CMD_LOW_THR, 16'h1234);
    reg_chk(CMD_LOW_THR, 16'h1234);
    reg_wr(CMD_HIGH_THR, 16'hFFFF);
    reg_chk(CMD_HIGH_THR, 16'hFFFF);
    reg_wr(CMD_CANCEL, 16'h0FFF);
    reg_chk(CMD_CANCEL, 16'h0FFF);
    reg_wr(CMD_RESULT, 16'h5555);
    reg_chk(CMD_RESULT, 16'h0000);
    reg_chk(8'h10, 16'h0000);
  endtask

  task automatic s_clamp();
    logic [15:0] e;
    reg_wr(CMD_MODE_CTRL, 16'h0010);
    for (int i = 0; i < 16; i++) begin
      range = 4'(i);
      e = 16'((32'h1 << (12 + range.integration_time + range.adc_gain_select)) - 1);
      trig(16'hFFFF);
      reg_chk(CMD_RESULT, range.high_dynamic_range ? e : 16'h0FFF);
    end
    reg_chk(CMD_MODE_CTRL, 16'h0010);
    base = n_done;
    repeat (2000) @(negedge mclk);
    check(16'(n_done), 16'(base));
  endtask

  task automatic s_events();
    range = 4'h0;
    reg_wr(CMD_LOW_THR, 16'h0064);
    reg_wr(CMD_HIGH_THR, 16'h03E8);
    u_host.rd(addr, CMD_EVENTS, d, nak);
    trig(16'h0032);
    reg_chk(CMD_RESULT, 16'h0032);
    reg_chk(CMD_EVENTS, 16'h0100);
    reg_chk(CMD_EVENTS, 16'h0000);
    trig(16'h07D0);
    reg_chk(CMD_EVENTS, 16'h0200);
    @(negedge mclk);
    sun = 1'b1;
    @(negedge mclk);
    sun = 1'b0;
    reg_chk(CMD_EVENTS, 16'h1000);
  endtask

  task automatic s_period();
    for (int k = 0; k < 4; k++) begin
      reg_wr(CMD_MODE_CTRL, {2'(k), 14'h0000});
      base = n_done;
      wait_done(base + 2);
      check(16'(t_last - t_prev >= PER[k] && t_last - t_prev <= PER[k] + 20), 16'h0001);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    swapped = 1'b0;
    sun = 1'b0;
    raw = 16'h0000;
    range = 4'h0;
    addr = ADDR_STRAIGHT;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    s_ident();
    s_regs();
    s_clamp();
    s_events();
    s_period();
    summarize();
  end
endmodule
`default_nettype wire
